// File: hw/dpam_pkg.sv
// Constants, types and encodings shared by the data port address-model unit.
// Assumes one clock, sys_clk at 125 MHz, and a plain register port.
//
// Contract
// - Accesses from one thread, address, port and coherency finish in issue order.
// - A fence holds the thread until all earlier messages are globally observed.
// - Four models: binding table, shared local memory, stateless 32 and 64 bit.
// - Shared local memory addresses add the per-dispatch local-memory base.
// - Surface and general addresses add programmed base plus message base offset.
// - Base address plus each lane offset gives each lane address.
// - Out-of-bounds reads return zero, out-of-bounds writes are discarded; a read with no enabled lane in bounds is not issued and never returns.
// - Table index below 240 selects a binding table entry as surface pointer; on the second data port the code selects stateless 32 or 64 instead.
// - Table index 252 takes surface pointer from extended descriptor offset; on the second data port the code selects stateless 32 or 64 instead.
// - Stateless 32 base is general base plus optional buffer base, no table.
// - Stateless 32 accesses are checked against the general buffer size.
// - Stateless surfaces are raw untiled buffers, byte pitch, zero line stride.
// - Stateless 64 uses the message graphics address as base, unchecked.
// - Stateless index 255 is coherent with the host cache hierarchy.
// - Stateless index 253 is non-coherent, coherent inside the unit only.
// - Alias coherency applies only to that single access.
// - L3 bypass accesses evict L3 lines and go straight to last-level cache.
// - Constant, sampler and render ports are always non-coherent.
// - Stateless messages without table index, and second data port, are host coherent.
// - Forced non-coherent mode makes every 32-bit address access non-coherent.
// - Index 254 selects shared local memory only on the data-cache port.
package dpam_pkg;

   //--------------------------------------------------------------------------
   // Sizes and special table indices.
   //--------------------------------------------------------------------------
   localparam int       DPAM_LANES      = 8;
   localparam int       DPAM_BT_DEPTH   = 240;
   localparam logic [7:0] DPAM_IDX_BT_END  = 8'hf0;
   localparam logic [7:0] DPAM_IDX_BINDLESS = 8'hfc;
   localparam logic [7:0] DPAM_IDX_NONCOH  = 8'hfd;
   localparam logic [7:0] DPAM_IDX_SLM     = 8'hfe;
   localparam logic [7:0] DPAM_IDX_COHERENT = 8'hff;

   //--------------------------------------------------------------------------
   // Register offsets and reset values.
   //--------------------------------------------------------------------------
   localparam logic [7:0]  DPAM_REG_CTRL      = 8'h00;
   localparam logic [7:0]  DPAM_REG_SS_BASE_L = 8'h04;
   localparam logic [7:0]  DPAM_REG_SS_BASE_H = 8'h08;
   localparam logic [7:0]  DPAM_REG_GS_BASE_L = 8'h0c;
   localparam logic [7:0]  DPAM_REG_GS_BASE_H = 8'h10;
   localparam logic [7:0]  DPAM_REG_GS_SIZE   = 8'h14;
   localparam logic [7:0]  DPAM_REG_SURF_LIM  = 8'h18;
   localparam logic [7:0]  DPAM_REG_SLM_LIM   = 8'h1c;
   localparam logic [7:0]  DPAM_REG_STATUS    = 8'h20;
   localparam logic [7:0]  DPAM_REG_BT_INDEX  = 8'h24;
   localparam logic [7:0]  DPAM_REG_BT_DATA   = 8'h28;
   localparam logic [31:0] DPAM_RST_WORD      = 32'h0000_0000;
   localparam logic [7:0]  DPAM_RST_COUNT     = 8'h00;

   //--------------------------------------------------------------------------
   // Encodings.
   //--------------------------------------------------------------------------
   typedef enum logic [1:0] {DPAM_PORT_DC = 2'h0, DPAM_PORT_DC2 = 2'h1,
                             DPAM_PORT_CONST = 2'h2, DPAM_PORT_RENDER = 2'h3} dpam_port_type;
   typedef enum logic [1:0] {DPAM_OP_READ = 2'h0, DPAM_OP_WRITE = 2'h1,
                             DPAM_OP_ATOMIC = 2'h2, DPAM_OP_FENCE = 2'h3} dpam_op_type;
   typedef enum logic [2:0] {DPAM_M_BTS = 3'h0, DPAM_M_SLM = 3'h1, DPAM_M_A32 = 3'h2,
                             DPAM_M_A64 = 3'h3, DPAM_M_NONE = 3'h4} dpam_model_type;
   typedef enum logic {DPAM_COH_NON = 1'b0, DPAM_COH_HOST = 1'b1} dpam_coh_type;
   typedef enum logic [1:0] {DPAM_ST_IDLE = 2'b01, DPAM_ST_HOLD = 2'b10} dpam_state_type;

   //--------------------------------------------------------------------------
   // Message from a thread and request toward the caches.
   //--------------------------------------------------------------------------
   typedef struct packed {
      dpam_op_type                      op;
      dpam_port_type                    port;
      logic [7:0]                       table_index;
      logic                             stateless_64;
      logic                             l3_bypass_access;
      logic [31:0]                      slm_base;
      logic [31:0]                      ss_offset;
      logic [31:0]                      buf_base;
      logic [63:0]                      gfx_addr;
      logic [DPAM_LANES-1:0]            lane_en;
      logic [DPAM_LANES-1:0][31:0]      offset;
      logic [DPAM_LANES-1:0][31:0]      wdata;
   } dpam_msg_type;

   typedef struct packed {
      logic                             valid;
      dpam_op_type                      op;
      dpam_model_type                   model;
      dpam_coh_type                     coh;
      logic                             l3_bypass_access;
      logic                             raw_buffer;
      logic [DPAM_LANES-1:0]            lane_en;
      logic [DPAM_LANES-1:0][63:0]      addr;
      logic [DPAM_LANES-1:0][31:0]      wdata;
   } dpam_req_type;

   typedef struct packed {
      logic [DPAM_LANES-1:0]            lane_en;
      logic [DPAM_LANES-1:0][31:0]      data;
   } dpam_rsp_type;

endpackage : dpam_pkg

// File: hw/dpam_unit.sv
// Address-model front end of the data port: decodes messages, forms lane
// addresses, bounds-checks lanes, picks coherency and enforces fences.
// Assumes messages, responses and register strobes are synchronous to sys_clk.
`timescale 1ns/1ps
`default_nettype none

module dpam_unit
   import dpam_pkg::*;
#(
   parameter int BT_DEPTH  = DPAM_BT_DEPTH,
   parameter int CNT_WIDTH = 8
) (
   // Clock and reset.
   input  wire logic                         sys_clk,
   input  wire logic                         rst_b,
   // Register port.
   input  wire logic [7:0]                   reg_addr,
   input  wire logic [31:0]                  reg_wdata,
   input  wire logic                         reg_wr,
   input  wire logic                         reg_rd,
   output logic      [31:0]                  reg_rdata,
   // Messages from execution threads.
   input  wire logic                         msg_valid,
   input  wire dpam_msg_type                 msg,
   output logic                              msg_ready,
   output logic                              fence_done,
   // Requests toward the cache hierarchy.
   output dpam_req_type                      mem_req,
   input  wire logic                         mem_done,
   // Read returns.
   input  wire logic                         rsp_valid,
   input  wire dpam_rsp_type                 rsp,
   output logic                              rd_valid,
   output logic      [DPAM_LANES-1:0][31:0]  rd_data
);

   //--------------------------------------------------------------------------
   // Storage.
   //--------------------------------------------------------------------------
   logic [31:0]          ctrl;
   logic [63:0]          ss_base;
   logic [63:0]          gs_base;
   logic [31:0]          gs_size;
   logic [31:0]          surf_limit;
   logic [31:0]          slm_limit;
   logic [7:0]           bt_index;
   logic [31:0]          bt_table [BT_DEPTH];
   logic [CNT_WIDTH-1:0] outstanding;
   dpam_state_type       state;

   //--------------------------------------------------------------------------
   // Register decode.
   //--------------------------------------------------------------------------
   // Control bit, table select check and the selected read value.
   wire logic        force_noncoh = ctrl[0];
   wire logic        bt_sel_ok    = (32'(bt_index) < BT_DEPTH);
   wire logic [31:0] bt_rd_word   = bt_sel_ok ? bt_table[bt_index] : DPAM_RST_WORD;
   wire logic [31:0] status_word  = {22'h00_0000, (state == DPAM_ST_HOLD), 1'h0,
                                     8'(outstanding)};
   wire logic [31:0] next_rdata   =
      !reg_rd                          ? 32'h0000_0000 :
      (reg_addr == DPAM_REG_CTRL)      ? ctrl :
      (reg_addr == DPAM_REG_SS_BASE_L) ? ss_base[31:0] :
      (reg_addr == DPAM_REG_SS_BASE_H) ? ss_base[63:32] :
      (reg_addr == DPAM_REG_GS_BASE_L) ? gs_base[31:0] :
      (reg_addr == DPAM_REG_GS_BASE_H) ? gs_base[63:32] :
      (reg_addr == DPAM_REG_GS_SIZE)   ? gs_size :
      (reg_addr == DPAM_REG_SURF_LIM)  ? surf_limit :
      (reg_addr == DPAM_REG_SLM_LIM)   ? slm_limit :
      (reg_addr == DPAM_REG_STATUS)    ? status_word :
      (reg_addr == DPAM_REG_BT_INDEX)  ? {24'h00_0000, bt_index} :
      (reg_addr == DPAM_REG_BT_DATA)   ? bt_rd_word : 32'h0000_0000;

   // Configuration registers written by software.
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         ctrl       <= DPAM_RST_WORD;
         ss_base    <= {DPAM_RST_WORD, DPAM_RST_WORD};
         gs_base    <= {DPAM_RST_WORD, DPAM_RST_WORD};
         gs_size    <= DPAM_RST_WORD;
         surf_limit <= DPAM_RST_WORD;
         slm_limit  <= DPAM_RST_WORD;
         bt_index   <= 8'h00;
      end else if (reg_wr) begin
         case (reg_addr)
            DPAM_REG_CTRL:      ctrl           <= {31'h0000_0000, reg_wdata[0]};
            DPAM_REG_SS_BASE_L: ss_base[31:0]  <= reg_wdata;
            DPAM_REG_SS_BASE_H: ss_base[63:32] <= reg_wdata;
            DPAM_REG_GS_BASE_L: gs_base[31:0]  <= reg_wdata;
            DPAM_REG_GS_BASE_H: gs_base[63:32] <= reg_wdata;
            DPAM_REG_GS_SIZE:   gs_size        <= reg_wdata;
            DPAM_REG_SURF_LIM:  surf_limit     <= reg_wdata;
            DPAM_REG_SLM_LIM:   slm_limit      <= reg_wdata;
            DPAM_REG_BT_INDEX:  bt_index       <= reg_wdata[7:0];
            default:            ;
         endcase
      end
   end

   // Binding table entries, written through the index register.
   always_ff @(posedge sys_clk) begin
      if (reg_wr && (reg_addr == DPAM_REG_BT_DATA) && bt_sel_ok) begin
         bt_table[bt_index] <= reg_wdata;
      end
   end

   // Read data stands only in the cycle after the read strobe.
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         reg_rdata <= DPAM_RST_WORD;
      end else begin
         reg_rdata <= next_rdata;
      end
   end

   //--------------------------------------------------------------------------
   // Address model decode.
   //--------------------------------------------------------------------------
   // Choose the model from table index and port.
   wire logic   take      = msg_valid && msg_ready;
   wire logic   is_fence  = (msg.op == DPAM_OP_FENCE);
   wire logic   is_dc     = (msg.port == DPAM_PORT_DC);
   wire logic   is_dc2    = (msg.port == DPAM_PORT_DC2);
   wire logic   sel_slm   = is_dc && (msg.table_index == DPAM_IDX_SLM);
   wire logic   sel_state = is_dc2 || (msg.table_index == DPAM_IDX_NONCOH) ||
                            (msg.table_index == DPAM_IDX_COHERENT);
   wire logic   sel_a64   = sel_state && msg.stateless_64;
   wire logic   sel_a32   = sel_state && !msg.stateless_64;
   wire logic   sel_bt    = !sel_state && (msg.table_index < DPAM_IDX_BT_END);
   wire logic   sel_bless = !sel_state && ((msg.table_index == DPAM_IDX_BINDLESS) ||
                            (!is_dc && (msg.table_index == DPAM_IDX_SLM)));
   wire logic   bt_hit    = sel_bt && (32'(msg.table_index) < BT_DEPTH);
   wire logic [31:0] bt_ptr = bt_hit ? bt_table[msg.table_index] : DPAM_RST_WORD;
   wire dpam_model_type model =
      sel_slm               ? DPAM_M_SLM :
      sel_a64               ? DPAM_M_A64 :
      sel_a32               ? DPAM_M_A32 :
      (bt_hit || sel_bless) ? DPAM_M_BTS : DPAM_M_NONE;

   // Base address of the surface for each model.
   wire logic [31:0] ss_ptr = sel_bless ? msg.ss_offset : bt_ptr;
   wire logic [63:0] base =
      (model == DPAM_M_SLM) ? {32'h0000_0000, msg.slm_base} :
      (model == DPAM_M_A64) ? msg.gfx_addr :
      (model == DPAM_M_A32) ? gs_base + {32'h0000_0000, msg.buf_base} :
      ss_base + {32'h0000_0000, ss_ptr} + {32'h0000_0000, msg.buf_base};

   // Bound that applies to each lane offset.
   wire logic        no_check = (model == DPAM_M_A64);
   wire logic [31:0] limit    =
      (model == DPAM_M_SLM) ? slm_limit :
      (model == DPAM_M_A32) ? gs_size : surf_limit;

   //--------------------------------------------------------------------------
   // Per-lane addresses and bounds.
   //--------------------------------------------------------------------------
   logic [DPAM_LANES-1:0]       lane_ok;
   logic [DPAM_LANES-1:0][63:0] lane_addr;

   genvar gl;
   generate
      for (gl = 0; gl < DPAM_LANES; gl++) begin : g_lane
         // Each lane is checked alone, so good lanes survive bad ones.
         assign lane_addr[gl] = base + {32'h0000_0000, msg.offset[gl]};
         assign lane_ok[gl]   = msg.lane_en[gl] && (model != DPAM_M_NONE) &&
                                (no_check || (msg.offset[gl] < limit));
      end
   endgenerate

   //--------------------------------------------------------------------------
   // Coherency selection.
   //--------------------------------------------------------------------------
   // Chosen per message and carried with it, never stored as shared state.
   wire logic ro_port = (msg.port == DPAM_PORT_CONST) || (msg.port == DPAM_PORT_RENDER);
   wire dpam_coh_type coh =
      ro_port                  ? DPAM_COH_NON :
      (sel_a32 && force_noncoh) ? DPAM_COH_NON :
      is_dc2                   ? DPAM_COH_HOST :
      (sel_state && (msg.table_index == DPAM_IDX_COHERENT)) ? DPAM_COH_HOST :
      DPAM_COH_NON;

   // Request formed from the message; only in-bounds lanes are enabled.
   wire logic   issue = take && !is_fence && (lane_ok != '0);
   dpam_req_type next_req;
   always_comb begin
      next_req                  = '0;
      next_req.valid            = issue;
      next_req.op               = msg.op;
      next_req.model            = model;
      next_req.coh              = coh;
      next_req.l3_bypass_access = msg.l3_bypass_access;
      next_req.raw_buffer       = sel_state;
      next_req.lane_en          = issue ? lane_ok : '0;
      next_req.addr             = lane_addr;
      next_req.wdata            = msg.wdata;
   end

   // One in-order stage keeps issue order for every thread.
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         mem_req <= '0;
      end else begin
         mem_req <= next_req;
      end
   end

   //--------------------------------------------------------------------------
   // Fence handling.
   //--------------------------------------------------------------------------
   // Messages in flight until the hierarchy reports them observed.
   wire logic [CNT_WIDTH-1:0] next_outstanding =
      outstanding + CNT_WIDTH'(issue) - CNT_WIDTH'(mem_done && (outstanding != '0));
   wire logic drained = (outstanding == '0);
   dpam_state_type next_state;
   always_comb begin
      case (state)
         DPAM_ST_IDLE: next_state = (take && is_fence) ? DPAM_ST_HOLD : DPAM_ST_IDLE;
         DPAM_ST_HOLD: next_state = drained ? DPAM_ST_IDLE : DPAM_ST_HOLD;
         default:      next_state = DPAM_ST_IDLE;
      endcase
   end

   // State, counter, ready and fence completion.
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         state       <= DPAM_ST_IDLE;
         outstanding <= '0;
         msg_ready   <= 1'b0;
         fence_done  <= 1'b0;
      end else begin
         state       <= next_state;
         outstanding <= next_outstanding;
         msg_ready   <= (next_state == DPAM_ST_IDLE);
         fence_done  <= (state == DPAM_ST_HOLD) && drained;
      end
   end

   //--------------------------------------------------------------------------
   // Read return.
   //--------------------------------------------------------------------------
   // Lanes the caches did not serve were disabled or out of bounds and read as zero.
   logic [DPAM_LANES-1:0][31:0] next_rd_data;
   generate
      for (gl = 0; gl < DPAM_LANES; gl++) begin : g_rd
         assign next_rd_data[gl] = rsp.lane_en[gl] ? rsp.data[gl] : 32'h0000_0000;
      end
   endgenerate

   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         rd_valid <= 1'b0;
         rd_data  <= '0;
      end else begin
         rd_valid <= rsp_valid;
         rd_data  <= rsp_valid ? next_rd_data : '0;
      end
   end

   //--------------------------------------------------------------------------
   // Checks.
   //--------------------------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_b);

   sequence s_fence_taken;
      take && is_fence;
   endsequence

   a_fence_blocks_ready: assert property (s_fence_taken |=>
      !msg_ready ##1 (msg_ready == fence_done))
      else $error("Ready stayed high after a fence was taken.");
   a_fence_needs_drain: assert property (fence_done |-> $past(drained))
      else $error("Fence completed with messages still in flight.");
   a_slm_lane_addr: assert property (take && sel_slm && lane_ok[0] |=>
      mem_req.addr[0] == $past(msg.slm_base) + $past(msg.offset[0]))
      else $error("Local memory lane address lacks the dispatch base.");
   a_a32_bound_drop: assert property (take && sel_a32 && !is_fence &&
      (msg.offset[0] >= gs_size) |=> !mem_req.lane_en[0])
      else $error("Out-of-bounds stateless lane was issued.");
   a_a64_no_check: assert property (take && sel_a64 && !is_fence && msg.lane_en[0]
      && !sel_slm |=> mem_req.lane_en[0] && mem_req.addr[0] ==
      $past(msg.gfx_addr) + {32'h0000_0000, $past(msg.offset[0])})
      else $error("Wide stateless lane was dropped or misaddressed.");
   a_alias_coherent: assert property (take && issue && is_dc && !msg.stateless_64 &&
      !force_noncoh && (msg.table_index == DPAM_IDX_COHERENT) |=> mem_req.coh == DPAM_COH_HOST)
      else $error("Coherent alias did not give host coherency.");
   a_ro_port_noncoh: assert property (issue && ro_port |=> mem_req.coh == DPAM_COH_NON)
      else $error("Read-only cache port issued a coherent access.");
   a_force_noncoh: assert property (issue && sel_a32 && force_noncoh |=>
      mem_req.coh == DPAM_COH_NON)
      else $error("Forced mode left a stateless access coherent.");
   a_oob_read_zero: assert property (rsp_valid && !rsp.lane_en[0] |=>
      rd_valid && (rd_data[0] == 32'h0000_0000))
      else $error("Unserved read lane returned non-zero data.");
   a_bindless_ptr: assert property (take && sel_bless && !sel_slm && msg.lane_en[0] &&
      (msg.offset[0] < surf_limit) && !is_fence |=> mem_req.addr[0] == $past(ss_base) +
      {32'h0000_0000, $past(msg.ss_offset)} + {32'h0000_0000, $past(msg.buf_base)} +
      {32'h0000_0000, $past(msg.offset[0])})
      else $error("Bindless lane address is wrong.");

endmodule : dpam_unit

`default_nettype wire

// File: tb/dpam_cache_model.sv
// Cache hierarchy model: completes requests in arrival order after lat cycles.
// Assumes one-cycle requests from the unit under test on sys_clk.
`timescale 1ns/1ps
`default_nettype none
module dpam_cache_model
   import dpam_pkg::*;
(
   // Clock, reset and delay.
   input  wire logic          sys_clk,
   input  wire logic          rst_b,
   input  wire logic [3:0]    lat,
   // Cache side.
   input  wire dpam_req_type  mem_req,
   output logic               mem_done,
   output logic               rsp_valid,
   output dpam_rsp_type       rsp
);
   dpam_req_type q[$];
   int           cnt;
   logic [31:0]  junk = 32'h1;

   // Return data keeps moving while idle, so a stale value never looks valid.
   always @(posedge sys_clk) begin
      mem_done <= 1'b0;
      rsp_valid <= 1'b0;
      junk <= {junk[30:0], junk[31] ^ junk[21]};
      rsp <= {~junk[7:0], {DPAM_LANES{junk}}};
      if (!rst_b) begin
         q.delete();
         cnt <= 0;
      end else begin
         if (mem_req.valid) q.push_back(mem_req);
         if (q.size() > 0 && cnt >= lat) begin
            mem_done <= 1'b1;
            if (q[0].op == DPAM_OP_READ) begin
               rsp_valid <= 1'b1;
               rsp.lane_en <= q[0].lane_en;
               for (int i = 0; i < DPAM_LANES; i++)
                  rsp.data[i] <= q[0].addr[i][31:0] ^ 32'h5a5a_5a5a;
            end
            void'(q.pop_front());
            cnt <= 0;
         end else if (q.size() > 0) cnt <= cnt + 1;
      end
   end
endmodule : dpam_cache_model
`default_nettype wire

// File: tb/dpam_unit_bench.sv
// Bench for the address-model unit: random messages per model, then a fence.
// Assumes dpam_cache_model stands in for the cache hierarchy.
`timescale 1ns/1ps
`default_nettype none
module dpam_unit_bench;
   import dpam_pkg::*;
   logic sys_clk = 1'b0, rst_b = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, msg_valid = 1'b0;
   logic [7:0] reg_addr = '0;
   logic [31:0] reg_wdata = '0, reg_rdata, seed = 32'd62, bufb, sso, slmb, ent;
   logic [63:0] gsb, ssb;
   logic [3:0] lat = '0;
   logic msg_ready, fence_done, mem_done, rsp_valid, rd_valid, seen;
   logic [DPAM_LANES-1:0][31:0] rd_data;
   dpam_msg_type msg = '0, m;
   dpam_req_type mem_req;
   dpam_rsp_type rsp;
   int error_cnt = 0, total_checks = 0, n;
   always #4 sys_clk = ~sys_clk;
   dpam_unit u_dpam_unit (.sys_clk(sys_clk), .rst_b(rst_b), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .msg_valid(msg_valid), .msg(msg), .msg_ready(msg_ready), .fence_done(fence_done),
      .mem_req(mem_req), .mem_done(mem_done), .rsp_valid(rsp_valid), .rsp(rsp),
      .rd_valid(rd_valid), .rd_data(rd_data));
   dpam_cache_model u_dpam_cache_model (.sys_clk(sys_clk), .rst_b(rst_b), .lat(lat),
      .mem_req(mem_req), .mem_done(mem_done), .rsp_valid(rsp_valid), .rsp(rsp));
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd
   task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
      total_checks++;
      if (got !== exp) begin
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
         error_cnt++;
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge sys_clk);
      {reg_rd, reg_addr} <= {1'b1, a};
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1 chk("register", e, reg_rdata);
   endtask : rd
   task automatic send(input dpam_msg_type x);
      @(posedge sys_clk);
      {msg_valid, msg} <= {1'b1, x};
      do @(posedge sys_clk); while (!msg_ready);
      msg_valid <= 1'b0;
   endtask : send
   // One random read through a given model; lim bit 32 means unchecked.
   task automatic run(input logic [7:0] idx, input dpam_port_type pt, input logic s64,
      input dpam_model_type md, input logic [63:0] base, input logic [32:0] lim,
      input logic [1:0] coh);
      logic [DPAM_LANES-1:0] en;
      m = '0;
      {m.port, m.table_index, m.stateless_64, m.gfx_addr} = {pt, idx, s64, base};
      {m.slm_base, m.ss_offset, m.buf_base, m.lane_en} = {slmb, sso, bufb, 8'(rnd())};
      for (int i = 0; i < DPAM_LANES; i++) begin
         m.offset[i] = rnd() % 32'h200;
         en[i] = m.lane_en[i] & (lim[32] | (m.offset[i] < lim[31:0]));
      end
      send(m);
      #1 n = 0;
      while (!mem_req.valid && n < 4) begin @(posedge sys_clk); #1; n++; end
      chk("issued", |en, mem_req.valid);
      if (|en) begin
         chk("model", md, mem_req.model);
         if (coh != 2'd2) chk("coherency", coh[0], mem_req.coh);
         if (md == DPAM_M_A32 || md == DPAM_M_A64) chk("raw", 1, mem_req.raw_buffer);
         chk("lanes", en, mem_req.lane_en);
         for (int i = 0; i < DPAM_LANES; i++)
            if (en[i]) chk("address", base + m.offset[i], mem_req.addr[i]);
         n = 0;
         do begin @(posedge sys_clk); #1; n++; end while (!rd_valid && n < 40);
         for (int i = 0; i < DPAM_LANES; i++)
            chk("data", en[i] ? (base[31:0] + m.offset[i]) ^ 32'h5a5a_5a5a : 0, rd_data[i]);
      end
   endtask : run
   task automatic results();
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : results
   // Watchdog against a hung handshake.
   initial begin
      #160000;
      error_cnt++;
      results();
   end
   // Main sequence: set up bases and limits, sweep every model, then fence.
   initial begin
      repeat (20) @(posedge sys_clk);
      rst_b <= 1'b1;
      repeat (2) @(posedge sys_clk);
      rd(DPAM_REG_STATUS, 32'h0);
      rd(8'h40, 32'h0);
      {gsb, ssb, ent} = {rnd(), rnd(), rnd(), rnd(), rnd()};
      wr(DPAM_REG_GS_BASE_L, gsb[31:0]);
      wr(DPAM_REG_GS_BASE_H, gsb[63:32]);
      wr(DPAM_REG_SS_BASE_L, ssb[31:0]);
      wr(DPAM_REG_SS_BASE_H, ssb[63:32]);
      wr(DPAM_REG_GS_SIZE, 32'h100);
      wr(DPAM_REG_SURF_LIM, 32'h180);
      wr(DPAM_REG_SLM_LIM, 32'h80);
      wr(DPAM_REG_BT_INDEX, 32'ha);
      wr(DPAM_REG_BT_DATA, ent);
      rd(DPAM_REG_GS_SIZE, 32'h100);
      for (int k = 0; k < 6; k++) begin
         lat <= 4'(rnd() % 8);
         {bufb, sso, slmb} = {rnd(), rnd(), rnd()};
         wr(DPAM_REG_CTRL, {31'h0, k[0]});
         run(8'hff, DPAM_PORT_DC, 0, DPAM_M_A32, gsb + bufb, 33'h100, {1'b0, !k[0]});
         run(8'hfd, DPAM_PORT_DC, 0, DPAM_M_A32, gsb + bufb, 33'h100, 2'd0);
         run(8'hff, DPAM_PORT_DC, 1, DPAM_M_A64, {rnd(), rnd()}, 33'h1_0000_0000, 1);
         run(8'hfe, DPAM_PORT_DC, 0, DPAM_M_SLM, {32'h0, slmb}, 33'h80, 2'd2);
         run(8'd10, DPAM_PORT_DC, 0, DPAM_M_BTS, ssb + ent + bufb, 33'h180, 2'd2);
         run(8'hfc, DPAM_PORT_DC, 0, DPAM_M_BTS, ssb + sso + bufb, 33'h180, 2'd2);
         run(8'hfe, DPAM_PORT_CONST, 0, DPAM_M_BTS, ssb + sso + bufb, 33'h180, 2'd0);
         run(8'h07, DPAM_PORT_DC2, 0, DPAM_M_A32, gsb + bufb, 33'h100, {1'b0, !k[0]});
      end
      lat <= 4'hf;
      m = '0;
      {m.table_index, m.lane_en} = {8'hff, 8'h01};
      send(m);
      repeat (2) @(posedge sys_clk);
      rd(DPAM_REG_STATUS, 32'h1);
      m.op = DPAM_OP_FENCE;
      send(m);
      {n, seen} = 0;
      do begin @(posedge sys_clk); #1; n++; seen |= mem_done; end while (!fence_done && n < 60);
      chk("fence", 1, seen & fence_done);
      chk("ready", 1, msg_ready);
      results();
   end
endmodule : dpam_unit_bench
`default_nettype wire
